// [design/spbl_strap_latch.v]
// strap capture at reset release, decode and firmware overrides
`timescale 1ns/1ps
`include "spbl_regs.vh"
module spbl_strap_latch #(
  parameter HOLD_CYC = `SPBL_HOLD_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // strap pins
  input wire rail_select_strap,
  input wire primary_boot_strap,
  input wire auxiliary_boot_strap,
  input wire log_timing_strap,
  input wire sdio_edge_strap,
  // pad control
  output reg [4:0] pull_up_en,
  output reg [4:0] pull_dn_en,
  output reg pin_func_en,
  // firmware overrides
  input wire fw_rail_wr,
  input wire fw_rail_val,
  input wire fw_sdio_wr,
  input wire [1:0] fw_sdio_val,
  // status and decoded settings
  output reg [4:0] strap_value,
  output reg strap_valid,
  output reg boot_spi,
  output reg boot_download,
  output reg rail_1v8,
  output reg console_log_en,
  output reg sdio_sample_rise,
  output reg sdio_output_rise
);
  // capture sequencer states
  localparam ST_HOLD = 1'b0;
  localparam ST_DONE = 1'b1;
  // the pin synchroniser needs four edges to fill and the capture comes on the next, so a hold shorter than five is stretched
  localparam integer CAP_CYC = (HOLD_CYC < `SPBL_MIN_CAP_CYC) ? `SPBL_MIN_CAP_CYC : HOLD_CYC;
  // wide enough for any hold window
  localparam integer CNT_W = 32;

  // raw and filtered strap levels
  wire [4:0] pins;
  wire [4:0] lvl;
  // firmware override holders
  wire rail_ovr_en;
  wire rail_ovr_val;
  wire sdio_ovr_en;
  wire [1:0] sdio_ovr_val;

  // capture sequencer
  reg state_q;
  reg state_d;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  reg cap_now;
  reg [4:0] latch_q;
  reg [4:0] latch_d;

  // next values of the registered outputs
  reg [4:0] pull_up_d;
  reg [4:0] pull_dn_d;
  reg pin_func_d;
  reg [4:0] strap_value_d;
  reg strap_valid_d;
  reg boot_spi_d;
  reg boot_download_d;
  reg rail_1v8_d;
  reg console_log_d;
  reg sdio_sample_d;
  reg sdio_output_d;

  // capture already taken
  function is_done;
    input st;
    begin
      is_done = (st == ST_DONE);
    end
  endfunction

  // download boot needs both boot straps low
  function download_sel;
    input [4:0] s;
    begin
      download_sel = !s[`SPBL_BIT_PRIM] && !s[`SPBL_BIT_AUX];
    end
  endfunction

  // flash boot needs only the primary strap high
  function spi_sel;
    input [4:0] s;
    begin
      spi_sel = s[`SPBL_BIT_PRIM];
    end
  endfunction

  // once written, a firmware override beats the strap bit
  function ovr_pick;
    input en;
    input ovr;
    input strap;
    begin
      ovr_pick = en ? ovr : strap;
    end
  endfunction

  // pulls stay on until the capture, then the pad is free
  function [4:0] pull_pick;
    input done;
    input [4:0] dflt;
    begin
      pull_pick = done ? 5'h00 : dflt;
    end
  endfunction

  assign pins[`SPBL_BIT_RAIL] = rail_select_strap;
  assign pins[`SPBL_BIT_PRIM] = primary_boot_strap;
  assign pins[`SPBL_BIT_AUX] = auxiliary_boot_strap;
  assign pins[`SPBL_BIT_LOG] = log_timing_strap;
  assign pins[`SPBL_BIT_SDIO] = sdio_edge_strap;

  spbl_sync #(
    .W(5)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(pins),
    .level_q(lvl)
  );

  // [RULE11] overrides after boot
  spbl_ovr #(
    .W(1)
  ) u_rail_ovr (
    .clk(clk),
    .rst_b(rst_b),
    .allow(state_q),
    .wr(fw_rail_wr),
    .wr_val(fw_rail_val),
    .en_q(rail_ovr_en),
    .val_q(rail_ovr_val)
  );

  spbl_ovr #(
    .W(2)
  ) u_sdio_ovr (
    .clk(clk),
    .rst_b(rst_b),
    .allow(state_q),
    .wr(fw_sdio_wr),
    .wr_val(fw_sdio_val),
    .en_q(sdio_ovr_en),
    .val_q(sdio_ovr_val)
  );

  // [RULE1] capture strobe at the end of the hold window
  always @* begin
    cap_now = 1'b0;
    if ((state_q == ST_HOLD) && (cnt_q == CAP_CYC - 1)) begin
      cap_now = 1'b1;
    end
  end

  // counter freezes after the capture so it can never wrap into a second one
  always @* begin
    cnt_d = cnt_q;
    if (state_q == ST_HOLD) begin
      cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_HOLD: begin
        if (cap_now) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        // only a reset leaves this state
        state_d = ST_DONE;
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
  end

  always @* begin
    // [RULE2] hold until reset
    latch_d = latch_q;
    // [RULE1] sample strap levels
    if (cap_now) begin
      latch_d = lvl;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_HOLD;
      cnt_q <= {CNT_W{1'b0}};
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // reset value is seen only before the first capture
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= `SPBL_STRAP_RST;
    end else begin
      latch_q <= latch_d;
    end
  end

  // pads keep pulls and strap role until the capture is taken
  always @* begin
    // [RULE6] hand pins back
    pull_up_d = pull_pick(is_done(state_q), `SPBL_PULL_UP_RST);
    pull_dn_d = pull_pick(is_done(state_q), `SPBL_PULL_DN_RST);
    pin_func_d = is_done(state_q);
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // [RULE4] weak pull defaults
      pull_up_en <= `SPBL_PULL_UP_RST;
      pull_dn_en <= `SPBL_PULL_DN_RST;
      pin_func_en <= 1'b0;
    end else begin
      pull_up_en <= pull_up_d;
      pull_dn_en <= pull_dn_d;
      pin_func_en <= pin_func_d;
    end
  end

  // decoded outputs follow the latch, never the live pins
  always @* begin
    // [RULE3] [RULE12] latched word readout
    strap_value_d = latch_q;
    strap_valid_d = is_done(state_q);
  end

  always @* begin
    // [RULE8] boot source decode
    boot_spi_d = is_done(state_q) && spi_sel(latch_q);
    boot_download_d = is_done(state_q) && download_sel(latch_q);
  end

  always @* begin
    // [RULE9] boot console enable
    console_log_d = is_done(state_q) && latch_q[`SPBL_BIT_LOG];
  end

  // rail and sdio show the empty latch before capture, so they read zero
  always @* begin
    // [RULE7] rail voltage select
    rail_1v8_d = ovr_pick(rail_ovr_en, rail_ovr_val, latch_q[`SPBL_BIT_RAIL]);
  end

  always @* begin
    // [RULE10] sdio edge select
    sdio_sample_d = ovr_pick(sdio_ovr_en, sdio_ovr_val[1], latch_q[`SPBL_BIT_LOG]);
    sdio_output_d = ovr_pick(sdio_ovr_en, sdio_ovr_val[0], latch_q[`SPBL_BIT_SDIO]);
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_value <= `SPBL_STRAP_RST;
      strap_valid <= 1'b0;
    end else begin
      strap_value <= strap_value_d;
      strap_valid <= strap_valid_d;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_spi <= 1'b0;
      boot_download <= 1'b0;
    end else begin
      boot_spi <= boot_spi_d;
      boot_download <= boot_download_d;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      console_log_en <= 1'b0;
    end else begin
      console_log_en <= console_log_d;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rail_1v8 <= 1'b0;
    end else begin
      rail_1v8 <= rail_1v8_d;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sdio_sample_rise <= 1'b0;
      sdio_output_rise <= 1'b0;
    end else begin
      sdio_sample_rise <= sdio_sample_d;
      sdio_output_rise <= sdio_output_d;
    end
  end
endmodule

// [design/spbl_regs.vh]
// field positions, reset values and timing counts of the strap boot latch
// Operation
// [RULE1] On release of any system reset the five strap input levels are captured as 0/1 bits.
// [RULE2] Captured strap bits stay unchanged until the next reset, whatever the pins do.
// [RULE3] All five captured strap bits are readable by software as one strap value word.
// [RULE4] During reset each strap pin gets its weak pull: rail and auxiliary low, others high.
// [RULE5] The outside party holds each strap pin at its wanted level while power comes up.
// [RULE6] After the capture the strap pins are handed back to their normal functions.
// [RULE7] A captured rail strap of 0 selects the 3.3 V flash rail and 1 selects 1.8 V.
// [RULE8] Primary strap 1 boots from SPI flash; primary and auxiliary both 0 is download boot.
// [RULE9] Log/timing strap 1 enables the boot console log, 0 keeps the console silent.
// [RULE10] Log/timing and SDIO edge straps pick SDIO sample edge and output edge respectively.
// [RULE11] After boot, firmware writes may override flash rail voltage and SDIO edge timing.
// [RULE12] The strap value word shows the captured bits, never the live pin levels.
`ifndef SPBL_REGS_VH
`define SPBL_REGS_VH

`define SPBL_NSTRAP 5
// bit positions inside the strap value word
`define SPBL_BIT_RAIL 0
`define SPBL_BIT_PRIM 1
`define SPBL_BIT_AUX 2
`define SPBL_BIT_LOG 3
`define SPBL_BIT_SDIO 4
// weak pull defaults per strap bit
`define SPBL_PULL_UP_RST 5'h1A
`define SPBL_PULL_DN_RST 5'h05
`define SPBL_STRAP_RST 5'h00
// strap hold time after power-up release
`define SPBL_HOLD_MS 1
`define SPBL_CLK_HZ 40000000
`define SPBL_HOLD_CYC ((`SPBL_HOLD_MS * `SPBL_CLK_HZ) / 1000)
// earliest capture, once the pin synchroniser has filled
`define SPBL_MIN_CAP_CYC 5

`endif

// [design/spbl_sync.v]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module spbl_sync #(
  parameter W = 5
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // pins and filtered levels
  input wire [W-1:0] pin,
  output reg [W-1:0] level_q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  integer i;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      level_q <= {W{1'b0}};
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // stage one is seen only by stage two
      for (i = 0; i < W; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// [design/spbl_ovr.v]
// firmware override holder, writable only once boot is done
`timescale 1ns/1ps
module spbl_ovr #(
  parameter W = 1
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // firmware write
  input wire allow,
  input wire wr,
  input wire [W-1:0] wr_val,
  // held override
  output reg en_q,
  output reg [W-1:0] val_q
);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= 1'b0;
      val_q <= {W{1'b0}};
    end else if (wr && allow) begin
      en_q <= 1'b1;
      val_q <= wr_val;
    end
  end
endmodule

// [verif/spbl_pins.sv]
// strap pins as set by external pulls or host gpio
`timescale 1ns/1ps
module spbl_pins (
  input wire [4:0] pull_up_en,
  input wire [4:0] pull_dn_en,
  input wire [4:0] drv_en,
  input wire [4:0] drv_val,
  input wire clk,
  output wire [4:0] pin
);
  // floating pin with no pull wanders
  reg [4:0] flip_q = 5'h00;
  always @(posedge clk) flip_q <= ~flip_q;
  assign pin = (drv_en & drv_val) | (~drv_en & (pull_up_en | (~pull_dn_en & flip_q)));
endmodule

// [verif/spbl_strap_latch_asserts.sv]
// port checks of the strap boot latch
`timescale 1ns/1ps
module spbl_strap_latch_asserts #(parameter HOLD_CYC = 40000) (
  input wire clk, rst_b, pin_func_en, fw_rail_wr, fw_rail_val, fw_sdio_wr, strap_valid,
  input wire boot_spi, boot_download, rail_1v8, console_log_en,
  input wire sdio_sample_rise, sdio_output_rise,
  input wire [1:0] fw_sdio_val,
  input wire [4:0] pull_up_en, pull_dn_en, strap_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // capture edge, with the same stretch for short holds as the design
  localparam int CAP = (HOLD_CYC < 5) ? 5 : HOLD_CYC;
  int cnt_q;
  always @(posedge clk or negedge rst_b)
    if (!rst_b) cnt_q <= 0;
    else if (cnt_q <= CAP) cnt_q <= cnt_q + 1;
  cap_time_a: assert property (strap_valid == (cnt_q > CAP))
    else $error("capture moment wrong");
  pull_rst_a: assert property (!strap_valid |-> pull_up_en == 5'h1A && pull_dn_en == 5'h05)
    else $error("pulls wrong before capture");
  hold_val_a: assert property (strap_valid |=> strap_valid && $stable(strap_value))
    else $error("latched value moved");
  pin_func_a: assert property (pin_func_en == strap_valid)
    else $error("pin function wrong");
  pull_free_a: assert property (strap_valid |-> pull_up_en == 5'h00 && pull_dn_en == 5'h00)
    else $error("pulls left on after capture");
  boot_src_a: assert property (strap_valid |-> boot_spi == strap_value[1]
    && boot_download == (strap_value[2:1] == 2'h0)) else $error("boot source wrong");
  log_en_a: assert property (console_log_en == (strap_valid && strap_value[3]))
    else $error("console log wrong");
  rail_ovr_a: assert property (fw_rail_wr && strap_valid |-> ##2 rail_1v8 == $past(fw_rail_val, 2))
    else $error("rail override wrong");
  sdio_ovr_a: assert property (fw_sdio_wr && strap_valid |-> ##2
    {sdio_sample_rise, sdio_output_rise} == $past(fw_sdio_val, 2)) else $error("sdio override wrong");
  cover property ($rose(strap_valid));
  cover property (fw_rail_wr && strap_valid);
  cover property (boot_download);
endmodule
bind spbl_strap_latch spbl_strap_latch_asserts #(.HOLD_CYC(HOLD_CYC)) chk_u (.clk(clk),
  .rst_b(rst_b), .pin_func_en(pin_func_en), .fw_rail_wr(fw_rail_wr), .fw_rail_val(fw_rail_val),
  .fw_sdio_wr(fw_sdio_wr), .strap_valid(strap_valid), .boot_spi(boot_spi),
  .boot_download(boot_download), .rail_1v8(rail_1v8), .console_log_en(console_log_en),
  .sdio_sample_rise(sdio_sample_rise), .sdio_output_rise(sdio_output_rise),
  .fw_sdio_val(fw_sdio_val), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
  .strap_value(strap_value));

// [verif/spbl_strap_latch_test.sv]
// random strap captures, pin abuse and firmware overrides
`timescale 1ns/1ps
module spbl_strap_latch_test;
  logic clk = 0, rst_b = 0, fw_rail_wr = 0, fw_rail_val = 0, fw_sdio_wr = 0;
  logic pf, vld, spi, dl, r18, lg, sr, orr;
  logic [1:0] fw_sdio_val = 0;
  logic [4:0] drv_en = 0, drv_val = 0, pin, pu, pd, sv, e;
  int err_count = 0, samples_checked = 0;
  initial forever #12.5 clk = ~clk;
  spbl_pins pins_u (.pull_up_en(pu), .pull_dn_en(pd), .drv_en(drv_en), .drv_val(drv_val),
    .clk(clk), .pin(pin));
  spbl_strap_latch #(.HOLD_CYC(8)) dut_u (.clk(clk), .rst_b(rst_b),
    .rail_select_strap(pin[0]), .primary_boot_strap(pin[1]), .auxiliary_boot_strap(pin[2]),
    .log_timing_strap(pin[3]), .sdio_edge_strap(pin[4]), .pull_up_en(pu), .pull_dn_en(pd),
    .pin_func_en(pf), .fw_rail_wr(fw_rail_wr), .fw_rail_val(fw_rail_val),
    .fw_sdio_wr(fw_sdio_wr), .fw_sdio_val(fw_sdio_val), .strap_value(sv), .strap_valid(vld),
    .boot_spi(spi), .boot_download(dl), .rail_1v8(r18), .console_log_en(lg),
    .sdio_sample_rise(sr), .sdio_output_rise(orr));
  function logic [5:0] dec(input logic [4:0] s);
    dec = {s[1], s[2:1] == 2'h0, s[0], s[3], s[3], s[4]};
  endfunction
  task cmp_any(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strap word
  task chk_word(input logic [4:0] got, input logic [4:0] exp);
    cmp_any({7'h00, got}, {7'h00, exp});
  endtask
  // decoded settings
  task chk_set(input logic [5:0] got, input logic [5:0] exp);
    cmp_any({6'h00, got}, {6'h00, exp});
  endtask
  // status and pad control: valid, pin function, pull-ups, pull-downs
  task chk_pad(input logic [11:0] got, input logic [11:0] exp);
    cmp_any(got, exp);
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    void'($urandom(80));
    for (int i = 0; i < 12; i++) begin
      @(negedge clk) rst_b = 0;
      drv_en = i == 0 ? 5'h00 : i < 3 ? 5'h1F : 5'($urandom);
      drv_val = i == 1 ? 5'h00 : i == 2 ? 5'h1F : 5'($urandom);
      e = (drv_en & drv_val) | (~drv_en & 5'h1A);
      repeat (20) @(negedge clk);
      // early write must be dropped
      rst_b = 1;
      fw_rail_wr = 1;
      fw_rail_val = ~e[0];
      @(negedge clk) fw_rail_wr = 0;
      chk_pad({vld, pf, pu, pd}, {2'h0, 5'h1A, 5'h05});
      repeat (11) @(negedge clk);
      chk_word(sv, e);
      chk_set({spi, dl, r18, lg, sr, orr}, dec(e));
      chk_pad({vld, pf, pu, pd}, 12'hC00);
      drv_en = 5'h1F;
      drv_val = ~e;
      repeat (6) @(negedge clk);
      chk_word(sv, e);
      chk_set({spi, dl, r18, lg, sr, orr}, dec(e));
      fw_rail_val = 1'($urandom);
      fw_sdio_val = 2'($urandom);
      fw_rail_wr = 1;
      fw_sdio_wr = 1;
      @(negedge clk) fw_rail_wr = 0;
      fw_sdio_wr = 0;
      repeat (3) @(negedge clk);
      chk_set({3'h0, r18, sr, orr}, {3'h0, fw_rail_val, fw_sdio_val});
    end
    report_and_stop;
  end
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    report_and_stop;
  end
endmodule
